/* File: rtl/msx_pkg.sv */
// Package for the move and shift instruction execution unit
package msx_pkg;

    localparam int FILE_ADDR_W  = 7;
    localparam int PTR_W        = 16;
    localparam int BANK_W       = 5;
    localparam int PAGE_W       = 7;
    localparam int OFFSET_W     = 6;
    localparam int NUM_PTR      = 2;

    localparam logic [7:0]       ACC_RESET   = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RESET = 5'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
    localparam logic [PTR_W-1:0] PTR_RESET   = 16'h0000;

    // Pointer update modes
    localparam logic [1:0] PTR_PRE_INC  = 2'h0;
    localparam logic [1:0] PTR_PRE_DEC  = 2'h1;
    localparam logic [1:0] PTR_POST_INC = 2'h2;
    localparam logic [1:0] PTR_POST_DEC = 2'h3;

    typedef enum logic [6:0] {
        OP_NONE          = 7'h01,
        OP_SHIFT_RIGHT   = 7'h02,
        OP_FILE_MOVE     = 7'h04,
        OP_INDIRECT_READ = 7'h08,
        OP_BANK_LITERAL  = 7'h10,
        OP_PAGE_LITERAL  = 7'h20,
        OP_ACC_LITERAL   = 7'h40
    } msx_op_type;

    typedef struct packed {
        msx_op_type             op;
        logic                   destSelect;
        logic [FILE_ADDR_W-1:0] fileAddr;
        logic                   ptrSelect;
        logic                   relativeForm;
        logic [1:0]             pointerUpdateSelect;
        logic [OFFSET_W-1:0]    offset;
        logic [7:0]             literal;
    } msx_instr_type;

    typedef struct packed {
        logic                   writeEn;
        logic                   indirect;
        logic [FILE_ADDR_W-1:0] fileAddr;
        logic [PTR_W-1:0]       indirectAddr;
        logic [7:0]             data;
    } msx_write_type;

endpackage

/* File: rtl/msx_exec.sv */
// Execution unit for shift, file move, indirect read and literal moves
// Function
// - Right shift: bits 7:1 to 6:0, bit 0 to borrow flag, bit 7 zero.
// - Shift result goes to accumulator when dest is 0, file register when 1.
// - File move with dest 0 copies register to accumulator, updates null flag.
// - File move with dest 1 writes value back, updating null flag.
// - Indirect read loads accumulator from pointer-addressed location, updates null flag.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; address matches.
// - Relative form uses pointer plus signed offset -32..31; pointer unchanged.
// - Indirect port has no storage; access goes to address in pointer.
// - Pointers are 16 bits and wrap at both ends without fault.
// - Bank literal loads 5-bit value into bank select; flags unchanged.
// - Page literal loads 7-bit value into page latch; flags unchanged.
// - Accumulator literal loads 8-bit value in one cycle; flags unchanged.
module msx_exec (
    input  wire logic                               clk,
    input  wire logic                               reset,
    input  wire logic                               instrValid,
    input  wire msx_pkg::msx_instr_type             instr,
    output logic [msx_pkg::FILE_ADDR_W-1:0]         fileReadAddr,
    input  wire logic [7:0]                         fileReadData,
    output logic [msx_pkg::PTR_W-1:0]               indirectReadAddr,
    input  wire logic [7:0]                         indirectReadData,
    output msx_pkg::msx_write_type                  memWrite,
    output logic [7:0]                              accumulator,
    output logic [msx_pkg::BANK_W-1:0]              bankSelect,
    output logic [msx_pkg::PAGE_W-1:0]              programCounterHighLatch,
    output logic [msx_pkg::PTR_W-1:0]               indirectPointer0,
    output logic [msx_pkg::PTR_W-1:0]               indirectPointer1,
    output logic                                    borrowOutFlag,
    output logic                                    nullResultFlag
);

    localparam int PW = msx_pkg::PTR_W;

    logic [7:0]                     acc_q;
    logic [msx_pkg::BANK_W-1:0]     bank_q;
    logic [msx_pkg::PAGE_W-1:0]     page_q;
    logic [PW-1:0]                  ptr_q [msx_pkg::NUM_PTR];
    logic [PW-1:0]                  ptrNext [msx_pkg::NUM_PTR];
    logic                           carry_q;
    logic                           zero_q;
    msx_pkg::msx_write_type         write_q;
    msx_pkg::msx_write_type         write_d;

    wire isShift    = instrValid && (instr.op == msx_pkg::OP_SHIFT_RIGHT);
    wire isMove     = instrValid && (instr.op == msx_pkg::OP_FILE_MOVE);
    wire isIndirect = instrValid && (instr.op == msx_pkg::OP_INDIRECT_READ);
    wire isBank     = instrValid && (instr.op == msx_pkg::OP_BANK_LITERAL);
    wire isPage     = instrValid && (instr.op == msx_pkg::OP_PAGE_LITERAL);
    wire isAccLit   = instrValid && (instr.op == msx_pkg::OP_ACC_LITERAL);

    // Right shift with zero into the top bit
    wire [7:0] shiftResult = {1'b0, fileReadData[7:1]};

    // Pointer arithmetic, wrapping naturally in 16 bits
    wire [PW-1:0] selPtr    = ptr_q[instr.ptrSelect];
    wire [PW-1:0] ptrInc    = selPtr + 16'h0001;
    wire [PW-1:0] ptrDec    = selPtr - 16'h0001;
    wire [PW-1:0] offsetExt = {{(PW-msx_pkg::OFFSET_W){instr.offset[msx_pkg::OFFSET_W-1]}},
                               instr.offset};
    wire [PW-1:0] relAddr   = selPtr + offsetExt;

    wire isPreInc  = instr.pointerUpdateSelect == msx_pkg::PTR_PRE_INC;
    wire isPreDec  = instr.pointerUpdateSelect == msx_pkg::PTR_PRE_DEC;
    wire isPostInc = instr.pointerUpdateSelect == msx_pkg::PTR_POST_INC;

    // Pre modes access the updated address, post modes the original one
    wire [PW-1:0] modeAddr = isPreInc ? ptrInc :
                             isPreDec ? ptrDec : selPtr;
    wire [PW-1:0] effAddr  = instr.relativeForm ? relAddr : modeAddr;
    wire [PW-1:0] updPtr   = (isPreInc || isPostInc) ? ptrInc : ptrDec;

    // Value whose zero test drives the null flag
    wire [7:0] flagValue = isShift ? shiftResult :
                           isMove  ? fileReadData : indirectReadData;
    wire       flagUpdate = isShift || isMove || isIndirect;
    wire       accLoad    = ((isShift || isMove) && !instr.destSelect)
                            || isIndirect || isAccLit;
    wire [7:0] accValue   = isAccLit ? instr.literal : flagValue;

    assign fileReadAddr     = instr.fileAddr;
    assign indirectReadAddr = effAddr;

    always_comb
    begin
        write_d              = '0;
        write_d.fileAddr     = instr.fileAddr;
        write_d.writeEn      = (isShift || isMove) && instr.destSelect;
        write_d.data         = isShift ? shiftResult : fileReadData;
    end

    generate
        for (genvar i = 0; i < msx_pkg::NUM_PTR; i++)
        begin : g_ptr
            wire ptrHit = isIndirect && !instr.relativeForm && (instr.ptrSelect == i);
            assign ptrNext[i] = ptrHit ? updPtr : ptr_q[i];

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    ptr_q[i] <= msx_pkg::PTR_RESET;
                else
                    ptr_q[i] <= ptrNext[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc_q   <= msx_pkg::ACC_RESET;
            bank_q  <= msx_pkg::BANK_RESET;
            page_q  <= msx_pkg::PAGE_RESET;
            carry_q <= 1'b0;
            zero_q  <= 1'b0;
            write_q <= '0;
        end
        else
        begin
            if (accLoad)
                acc_q <= accValue;
            if (isBank)
                bank_q <= instr.literal[msx_pkg::BANK_W-1:0];
            if (isPage)
                page_q <= instr.literal[msx_pkg::PAGE_W-1:0];
            if (isShift)
                carry_q <= fileReadData[0];
            if (flagUpdate)
                zero_q <= (flagValue == 8'h00);
            write_q <= write_d;
        end
    end

    assign accumulator             = acc_q;
    assign bankSelect              = bank_q;
    assign programCounterHighLatch = page_q;
    assign indirectPointer0        = ptr_q[0];
    assign indirectPointer1        = ptr_q[1];
    assign borrowOutFlag           = carry_q;
    assign nullResultFlag          = zero_q;
    assign memWrite                = write_q;

endmodule // msx_exec

/* File: verif/msx_exec_props.sv */
// Assertion checker for the move and shift execution unit
module msx_exec_props (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   instrValid,
    input wire msx_pkg::msx_instr_type instr,
    input wire logic [7:0]             fileReadData,
    input wire logic [15:0]            indirectReadAddr,
    input wire logic [7:0]             indirectReadData,
    input wire msx_pkg::msx_write_type memWrite,
    input wire logic [7:0]             accumulator,
    input wire logic [15:0]            indirectPointer0,
    input wire logic                   borrowOutFlag,
    input wire logic                   nullResultFlag
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic        sh, mv, ind, a0;
    logic [15:0] step, ea, nxt;
    assign sh   = instrValid && instr.op == msx_pkg::OP_SHIFT_RIGHT;
    assign mv   = instrValid && instr.op == msx_pkg::OP_FILE_MOVE;
    assign ind  = instrValid && instr.op == msx_pkg::OP_INDIRECT_READ;
    assign a0   = ind && !instr.ptrSelect;
    assign step = instr.pointerUpdateSelect[0] ? 16'hffff : 16'h0001;
    assign ea   = indirectPointer0 + (instr.relativeForm ? {{10{instr.offset[5]}}, instr.offset}
                  : instr.pointerUpdateSelect[1] ? 16'h0000 : step);
    assign nxt  = indirectPointer0 + (instr.relativeForm ? 16'h0000 : step);
    property p_shA; sh && !instr.destSelect |=> accumulator == $past(fileReadData) >> 1; endproperty
    a_shA: assert property (p_shA) else $error("shift result wrong");
    property p_shC; sh |=> borrowOutFlag == $past(fileReadData[0]); endproperty
    a_shC: assert property (p_shC) else $error("shift borrow wrong");
    property p_wr; (sh || mv) && instr.destSelect |=> memWrite.writeEn && $stable(accumulator);
    endproperty
    a_wr: assert property (p_wr) else $error("write back wrong");
    property p_z; mv |=> nullResultFlag == ($past(fileReadData) == 8'h00); endproperty
    a_z: assert property (p_z) else $error("null flag wrong");
    property p_ld; ind || mv && !instr.destSelect
        |=> accumulator == $past(ind ? indirectReadData : fileReadData); endproperty
    a_ld: assert property (p_ld) else $error("load wrong");
    property p_ea; a0 |-> indirectReadAddr == ea; endproperty
    a_ea: assert property (p_ea) else $error("address wrong");
    property p_ptr; a0 |=> indirectPointer0 == $past(nxt); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer wrong");
    property p_lit; instrValid && |instr.op[6:4] |=> $stable({nullResultFlag, borrowOutFlag});
    endproperty
    a_lit: assert property (p_lit) else $error("flags moved");
endmodule // msx_exec_props
bind msx_exec msx_exec_props i_props (.*);

/* File: verif/msx_exec_tb_top.sv */
// Self-checking bench for the move and shift execution unit
`define CHK(a, b) checked++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t %h %h", $time, a, b); end
module msx_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk = 1'b0;
    logic                   reset, instrValid, borrowOutFlag, nullResultFlag;
    msx_pkg::msx_instr_type instr;
    msx_pkg::msx_write_type memWrite;
    logic [6:0]             fileReadAddr, programCounterHighLatch;
    logic [7:0]             fileReadData, indirectReadData, accumulator, fv;
    logic [15:0]            indirectReadAddr, indirectPointer0, indirectPointer1;
    logic [4:0]             bankSelect;
    int                     n_fail = 0;
    int                     checked = 0;
    // Wrong file address returns inverted data
    assign fileReadData     = fileReadAddr == 7'h05 ? fv : ~fv;
    assign indirectReadData = indirectReadAddr[7:0] ^ indirectReadAddr[15:8];
    msx_exec i_dut (.*);
    initial forever #12.5 clk = ~clk;
    // Relative form always goes through the second pointer
    task automatic run(msx_pkg::msx_op_type op, logic [7:0] k, logic d = 0, logic [1:0] m = 0,
                       logic r = 0);
        @(posedge clk);
        instr      <= '{op, d, 7'h05, r, r, m, k[5:0], k};
        instrValid <= 1'b1;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    task automatic t_shift();
        fv = 8'h80;
        run(msx_pkg::OP_SHIFT_RIGHT, 8'h00);
        `CHK({accumulator, borrowOutFlag, nullResultFlag}, 10'h100)
        fv = 8'h01;
        run(msx_pkg::OP_SHIFT_RIGHT, 8'h00, 1'b1);
        `CHK({accumulator, borrowOutFlag, nullResultFlag}, 10'h103)
        `CHK({memWrite.writeEn, memWrite.data}, 9'h100)
    endtask
    task automatic t_move();
        fv = 8'h00;
        run(msx_pkg::OP_FILE_MOVE, 8'h00, 1'b1);
        `CHK({accumulator, nullResultFlag, memWrite.writeEn, memWrite.data}, 18'h10300)
        fv = 8'h9c;
        run(msx_pkg::OP_FILE_MOVE, 8'h00);
        `CHK({accumulator, nullResultFlag}, 9'h138)
    endtask
    task automatic t_ind();
        logic [1:0]  m [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [15:0] a [4] = '{16'h0001, 16'h0000, 16'h0000, 16'hffff};
        logic [15:0] p [4] = '{16'h0001, 16'h0000, 16'hffff, 16'h0000};
        for (int i = 0; i < 4; i++)
        begin
            run(msx_pkg::OP_INDIRECT_READ, 8'h00, 1'b0, m[i]);
            `CHK({indirectPointer0, accumulator}, {p[i], a[i][7:0] ^ a[i][15:8]})
        end
        `CHK(nullResultFlag, 1'b1)
        run(msx_pkg::OP_INDIRECT_READ, 8'h20, 1'b0, 2'h0, 1'b1);
        `CHK({indirectPointer1, indirectPointer0, accumulator}, 40'h000000001f)
    endtask
    task automatic t_lit();
        run(msx_pkg::OP_BANK_LITERAL, 8'hff);
        run(msx_pkg::OP_PAGE_LITERAL, 8'hff);
        run(msx_pkg::OP_ACC_LITERAL, 8'h00);
        run(msx_pkg::OP_NONE, 8'h55);
        `CHK({bankSelect, programCounterHighLatch, accumulator}, 20'hfff00)
        `CHK({borrowOutFlag, nullResultFlag}, 2'h2)
    endtask
    task automatic final_report();
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        reset      = 1'b1;
        instrValid = 1'b0;
        instr      = '0;
        fv         = 8'h00;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_shift();
        t_move();
        t_ind();
        t_lit();
        final_report();
    end
endmodule // msx_exec_tb_top
